/* File: logic/sms_core.sv */
// sms_core: full-duplex serial port, master or slave, with its register file
// assumes: register port on core_clk; serial pins asynchronous, bench resolves the wires
//
// Operation
// - master starts every frame; both data lines shift together on one clock
// - word length programmable from 4 to 32 bits
// - bit-order 0 sends MSB first, 1 sends LSB first
// - clock idle level sets master SCK rest level; slave decodes SCK edges against it
// - phase 1 samples on second edge, 0 on first; outputs change opposite
// - master SCK runs at half the core clock
// - master drives select at its programmed active level; 3-wire master leaves select undriven
// - slave selected while its select input is at programmed level; 3-wire slave selected while emu bit is 0
// - 4-wire master drives select to its active level on transmit write, returns it to the inactive level after frame
// - extra SCK edges within a selected frame set the over-length flag
// - writing 0 clears over-length and under-length flags
// - slave deselected early sets under-length; partial word still received
// - master busy rises at start, clears when frame ends or stops
// - slave busy is high while selected
// - transmit flag set when holding register moves into shifter
// - receive flag set when shifter moves into receive register
// - receive-update flag marks the receive register being updated
// - registers at 0x00, 0x04, 0x08, 0x0C
// - new word into a full receive register sets data-lost; read clears
// - receive-full flag set on new word, cleared by read
// - mode field selects 4-wire, 3-wire or TI mode; TI runs with the 4-wire framing
// - MSB-first words left-justified, LSB-first right-justified
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

module sms_core
  import sms_pkg::*;
#(
  parameter int ADDR_W = SMS_AW
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [SMS_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [SMS_DW-1:0] reg_rdata,
  // serial pins
  input  wire sms_pins_t         pin_in,
  output sms_pins_t              pin_out,
  output sms_pins_t              pin_oe
);

  if (ADDR_W < SMS_AW) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  sms_ctrl_t         ctrl_q;
  sms_frame_t        frame_q;
  sms_mst_state_t    st_q;
  sms_pins_t         s1_q;
  sms_pins_t         s2_q;
  logic              sck_s3_q;
  logic              sel_q;
  logic              sck_q;
  logic              cs_q;
  logic [SMS_EW-1:0] edge_cnt_q;
  logic [SMS_CW-1:0] bit_cnt_q;
  logic [SMS_DW-1:0] tx_holding_reg_q;
  logic [SMS_DW-1:0] rx_holding_reg_q;
  logic [SMS_DW-1:0] tx_sh_q;
  logic [SMS_DW-1:0] rx_sh_q;
  logic              tx_full_q;
  logic              rx_full_q;
  logic              lost_q;
  logic              over_q;
  logic              under_q;
  logic              tx_irq_q;
  logic              rx_irq_q;
  logic              rx_upd_q;

  function automatic logic [SMS_CW-1:0] word_len(input logic [4:0] code);
    case (code)
      WL_CODE_8:  word_len = WL_LEN_8;
      WL_CODE_16: word_len = WL_LEN_16;
      WL_CODE_24: word_len = WL_LEN_24;
      default:    word_len = {1'b0, code} + SMS_ONE_C;
    endcase
  endfunction

  function automatic logic [SMS_DW-1:0] shift_in(input logic [SMS_DW-1:0] v,
                                                 input logic b, input logic lsb);
    shift_in = lsb ? {b, v[SMS_DW-1:1]} : {v[SMS_DW-2:0], b};
  endfunction

  // left-justify for MSB first, right-justify for LSB first
  function automatic logic [SMS_DW-1:0] justify(input logic [SMS_DW-1:0] v,
                                                input logic [SMS_CW-1:0] n, input logic lsb);
    logic [SMS_EW-1:0] gap;
    gap = SMS_FULL_W - {1'b0, n};
    justify = lsb ? (v >> gap) : (v << gap);
  endfunction

  // register decode
  logic [3:0] a;
  logic       hit;
  assign a   = reg_addr[SMS_AW-1:0];
  assign hit = (reg_addr >> SMS_AW) == '0;

  logic wr_ctrl;
  logic wr_frame;
  logic wr_tx;
  logic rd_rx;
  assign wr_ctrl  = reg_wr & hit & (a == SMS_OFF_CTRL);
  assign wr_frame = reg_wr & hit & (a == SMS_OFF_FRAME);
  assign wr_tx    = reg_wr & hit & (a == SMS_OFF_TX);
  assign rd_rx    = reg_rd & hit & (a == SMS_OFF_RX);

  // mode and selection
  logic [SMS_CW-1:0] wlen;
  logic              is_mst;
  logic              is_slv;
  logic              three_w;
  logic              sel_now;
  assign wlen    = word_len(frame_q.wlen);
  assign is_mst  = ctrl_q.en & ctrl_q.master;
  assign is_slv  = ctrl_q.en & ~ctrl_q.master;
  // TI mode is run with the 4-wire framing
  assign three_w = frame_q.mode == MODE_3WIRE;
  assign sel_now = is_slv & (three_w ? ~frame_q.emu : s2_q.cs == frame_q.cspol);

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q     <= '0;
      s2_q     <= '0;
      sck_s3_q <= 1'b0;
      sel_q    <= 1'b0;
    end else begin
      s1_q     <= pin_in;
      s2_q     <= s1_q;
      sck_s3_q <= s2_q.sck;
      sel_q    <= sel_now;
    end
  end

  // edge classification for both roles
  logic edge_ev;
  logic lead_ev;
  logic in_bit;
  logic smp_ev;
  logic shf_ev;
  always_comb begin
    if (is_mst) begin
      edge_ev = st_q == ST_RUN;
      lead_ev = sck_q == ctrl_q.clock_idle_level;
      in_bit  = s2_q.miso;
    end else begin
      edge_ev = sel_q & sel_now & (s2_q.sck != sck_s3_q);
      lead_ev = s2_q.sck != ctrl_q.clock_idle_level;
      in_bit  = s2_q.mosi;
    end
    smp_ev = edge_ev & (lead_ev ^ ctrl_q.sample_edge_sel);
    // phase 1: first edge only presents the first bit, no shift
    shf_ev = edge_ev & ~(lead_ev ^ ctrl_q.sample_edge_sel) & (bit_cnt_q != '0);
  end

  logic [1:0]        m_smp_q;
  logic [1:0]        m_hold_q;
  logic              rx_ev;
  logic              m_start;
  logic              s_start;
  logic              start;
  logic              s_word;
  logic              s_short;
  logic              m_done;
  logic              rx_load;
  logic              ov_set;
  logic [SMS_DW-1:0] rx_next;
  logic [SMS_DW-1:0] rx_src;
  logic [SMS_EW-1:0] last_edge;
  assign m_start   = is_mst & (st_q == ST_IDLE) & tx_full_q;
  assign s_start   = sel_now & ~sel_q;
  assign start     = m_start | s_start;
  assign rx_next   = shift_in(rx_sh_q, in_bit, frame_q.lsb);
  assign s_word    = ~is_mst & smp_ev & (bit_cnt_q == wlen - SMS_ONE_C);
  assign s_short   = sel_q & ~sel_now & (bit_cnt_q != '0) & (bit_cnt_q < wlen);
  assign m_done    = is_mst & m_hold_q[1];
  assign rx_ev     = is_mst ? m_smp_q[1] : smp_ev;
  assign rx_load   = m_done | s_word | s_short;
  assign ov_set    = smp_ev & (bit_cnt_q >= wlen);
  assign last_edge = {wlen, 1'b0} - SMS_ONE_E;
  assign rx_src    = s_word ? justify(rx_next, wlen, frame_q.lsb)
                            : justify(rx_sh_q, bit_cnt_q, frame_q.lsb);

  // master frame sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else if (!is_mst) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE:  st_q <= m_start ? ST_SETUP : ST_IDLE;
        ST_SETUP: st_q <= ST_RUN;
        ST_RUN:   st_q <= (edge_cnt_q == last_edge) ? ST_HOLD : ST_RUN;
        ST_HOLD:  st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  // master input lags its pin by the two sync flops; sample and load late to match
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_smp_q  <= '0;
      m_hold_q <= '0;
    end else begin
      m_smp_q  <= {m_smp_q[0], is_mst & smp_ev};
      m_hold_q <= {m_hold_q[0], st_q == ST_HOLD};
    end
  end

  // serial clock: one toggle per core clock, idle level otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q      <= 1'b0;
      edge_cnt_q <= '0;
    end else begin
      if (st_q == ST_RUN) begin
        sck_q <= ~sck_q;
      end else begin
        sck_q <= ctrl_q.clock_idle_level;
      end
      if (m_start) begin
        edge_cnt_q <= '0;
      end else if (st_q == ST_RUN) begin
        edge_cnt_q <= edge_cnt_q + SMS_ONE_E;
      end
    end
  end

  // select output held active from start until the hold cycle ends
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= 1'b1;
    end else if (m_start || st_q == ST_SETUP || st_q == ST_RUN) begin
      cs_q <= frame_q.cspol;
    end else begin
      cs_q <= ~frame_q.cspol;
    end
  end

  // shifters and bit counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q   <= SMS_RST_WORD;
      rx_sh_q   <= SMS_RST_WORD;
      bit_cnt_q <= '0;
    end else begin
      if (start) begin
        tx_sh_q <= tx_holding_reg_q;
      end else if (shf_ev) begin
        tx_sh_q <= frame_q.lsb ? (tx_sh_q >> 1) : (tx_sh_q << 1);
      end
      if (start) begin
        rx_sh_q <= SMS_RST_WORD;
      end else if (rx_ev) begin
        rx_sh_q <= rx_next;
      end
      if (start) begin
        bit_cnt_q <= '0;
      end else if (smp_ev && ~&bit_cnt_q) begin
        bit_cnt_q <= bit_cnt_q + SMS_ONE_C;
      end
    end
  end

  logic tx_bit;
  assign tx_bit = frame_q.lsb ? tx_sh_q[0] : tx_sh_q[SMS_DW-1];

  always_comb begin
    pin_out.sck  = sck_q;
    pin_out.cs   = cs_q;
    pin_out.mosi = tx_bit;
    pin_out.miso = tx_bit;
    pin_oe.sck   = is_mst;
    pin_oe.mosi  = is_mst;
    pin_oe.cs    = is_mst & ~three_w;
    pin_oe.miso  = sel_q;
  end

  // configuration and transmit holding register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q           <= '0;
      frame_q          <= '0;
      tx_holding_reg_q <= SMS_RST_WORD;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.en     <= reg_wdata[B_EN];
        ctrl_q.master <= reg_wdata[B_MASTER];
        ctrl_q.clock_idle_level   <= reg_wdata[B_CLOCK_IDLE_LEVEL];
        ctrl_q.sample_edge_sel   <= reg_wdata[B_SAMPLE_EDGE_SEL];
      end
      if (wr_frame) begin
        frame_q.wlen  <= reg_wdata[F_WLEN +: 5];
        frame_q.mode  <= reg_wdata[F_MODE +: 2];
        frame_q.lsb   <= reg_wdata[F_LSB];
        frame_q.cspol <= reg_wdata[F_CSPL];
        frame_q.emu   <= reg_wdata[F_EMU];
      end
      if (wr_tx) begin
        tx_holding_reg_q <= reg_wdata;
      end
    end
  end

  // receive holding register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_holding_reg_q <= SMS_RST_WORD;
      rx_upd_q         <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_holding_reg_q <= rx_src;
      end
      rx_upd_q <= rx_load;
    end
  end

  // status flags; a hardware set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_full_q <= 1'b0;
      rx_full_q <= 1'b0;
      lost_q    <= 1'b0;
      over_q    <= 1'b0;
      under_q   <= 1'b0;
      tx_irq_q  <= 1'b0;
      rx_irq_q  <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_full_q <= 1'b1;
      end else if (start) begin
        tx_full_q <= 1'b0;
      end
      if (rx_load) begin
        rx_full_q <= 1'b1;
      end else if (rd_rx) begin
        rx_full_q <= 1'b0;
      end
      if (rx_load && rx_full_q) begin
        lost_q <= 1'b1;
      end else if (rd_rx) begin
        lost_q <= 1'b0;
      end
      if (ov_set) begin
        over_q <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[B_OVER]) begin
        over_q <= 1'b0;
      end
      if (s_short) begin
        under_q <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[B_UNDER]) begin
        under_q <= 1'b0;
      end
      if (start) begin
        tx_irq_q <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[B_TXIRQ]) begin
        tx_irq_q <= 1'b0;
      end
      if (rx_load) begin
        rx_irq_q <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[B_RXIRQ]) begin
        rx_irq_q <= 1'b0;
      end
    end
  end

  logic busy;
  assign busy = is_mst ? (st_q != ST_IDLE) : sel_q;

  // read path: data valid only in the cycle after the strobe
  logic [SMS_DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (a)
      SMS_OFF_CTRL: begin
        rd_mux[B_EN]     = ctrl_q.en;
        rd_mux[B_MASTER] = ctrl_q.master;
        rd_mux[B_CLOCK_IDLE_LEVEL]   = ctrl_q.clock_idle_level;
        rd_mux[B_SAMPLE_EDGE_SEL]   = ctrl_q.sample_edge_sel;
        rd_mux[B_RXIRQ]  = rx_irq_q;
        rd_mux[B_TXIRQ]  = tx_irq_q;
        rd_mux[B_RXFULL] = rx_full_q;
        rd_mux[B_TXFULL] = tx_full_q;
        rd_mux[B_DLOST]  = lost_q;
        rd_mux[B_BUSY]   = busy;
        rd_mux[B_UNDER]  = under_q;
        rd_mux[B_OVER]   = over_q;
        rd_mux[B_RXUPD]  = rx_upd_q;
      end
      SMS_OFF_FRAME: begin
        rd_mux[F_WLEN +: 5] = frame_q.wlen;
        rd_mux[F_MODE +: 2] = frame_q.mode;
        rd_mux[F_LSB]       = frame_q.lsb;
        rd_mux[F_CSPL]      = frame_q.cspol;
        rd_mux[F_EMU]       = frame_q.emu;
      end
      SMS_OFF_RX: rd_mux = rx_holding_reg_q;
      SMS_OFF_TX: rd_mux = tx_holding_reg_q;
      default:    rd_mux = '0;
    endcase
    if (!hit) begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= SMS_RST_WORD;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : SMS_RST_WORD;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_sck_idle;
    is_mst && st_q == ST_IDLE && $past(st_q) == ST_IDLE && $stable(ctrl_q.clock_idle_level)
      |-> pin_out.sck == ctrl_q.clock_idle_level;
  endproperty
  a_sck_idle:
    assert property (p_sck_idle) else $error("sck not at idle level");

  property p_sck_half;
    st_q == ST_RUN && $past(st_q) == ST_RUN |-> sck_q != $past(sck_q);
  endproperty
  a_sck_half:
    assert property (p_sck_half) else $error("sck not toggling every cycle");

  property p_start;
    m_start |=> st_q == ST_SETUP && busy && pin_out.cs == frame_q.cspol ##1 st_q == ST_RUN;
  endproperty
  a_start:
    assert property (p_start) else $error("master start sequence wrong");

  property p_cs_run;
    st_q == ST_RUN |-> pin_out.cs == frame_q.cspol;
  endproperty
  a_cs_run:
    assert property (p_cs_run) else $error("select not active during frame");

  property p_frame_end;
    st_q == ST_HOLD |-> edge_cnt_q == {wlen, 1'b0} && pin_out.sck == ctrl_q.clock_idle_level
      ##1 pin_out.cs != frame_q.cspol && !busy;
  endproperty
  a_frame_end:
    assert property (p_frame_end) else $error("wrong edge count or release order");

  property p_first_bit;
    start && !frame_q.lsb |=> pin_out.mosi == $past(tx_holding_reg_q[SMS_DW-1]);
  endproperty
  a_first_bit:
    assert property (p_first_bit) else $error("msb not presented first");

  property p_rx_load;
    rx_load |=> rx_full_q && rx_irq_q && rx_upd_q;
  endproperty
  a_rx_load:
    assert property (p_rx_load) else $error("receive load flags missing");

  property p_lost;
    rx_load && rx_full_q |=> lost_q;
  endproperty
  a_lost:
    assert property (p_lost) else $error("data lost flag not set");

  property p_over;
    ov_set |=> over_q;
  endproperty
  a_over:
    assert property (p_over) else $error("over-length flag not set");

  property p_clear;
    wr_ctrl && !reg_wdata[B_OVER] && !ov_set |=> !over_q;
  endproperty
  a_clear:
    assert property (p_clear) else $error("over-length flag not cleared");

  property p_under;
    s_short |=> under_q && rx_full_q;
  endproperty
  a_under:
    assert property (p_under) else $error("under-length not flagged");

  property p_slave_sel;
    is_slv && !three_w && s2_q.cs != frame_q.cspol |=> !sel_q && !pin_oe.miso;
  endproperty
  a_slave_sel:
    assert property (p_slave_sel) else $error("slave selected at wrong level");

  c_master_frame: cover property (st_q == ST_HOLD);
  c_slave_word:   cover property (s_word);
  c_under:        cover property (s_short);
  c_over:         cover property (ov_set);

endmodule

/* File: include/sms_pkg.sv */
// sms_pkg: register map, field positions, states and carrier types of the serial port
// assumes: compiled before the serial port core
package sms_pkg;

  localparam int SMS_DW = 32;
  localparam int SMS_AW = 4;
  localparam int SMS_CW = 6;
  localparam int SMS_EW = 7;

  // register offsets
  localparam logic [3:0] SMS_OFF_CTRL  = 4'h0;
  localparam logic [3:0] SMS_OFF_FRAME = 4'h4;
  localparam logic [3:0] SMS_OFF_RX    = 4'h8;
  localparam logic [3:0] SMS_OFF_TX    = 4'hC;

  // control_status bit positions
  localparam int B_EN     = 0;
  localparam int B_MASTER = 1;
  localparam int B_CLOCK_IDLE_LEVEL   = 2;
  localparam int B_SAMPLE_EDGE_SEL   = 3;
  localparam int B_RXIRQ  = 4;
  localparam int B_TXIRQ  = 5;
  localparam int B_RXFULL = 16;
  localparam int B_TXFULL = 17;
  localparam int B_DLOST  = 18;
  localparam int B_BUSY   = 19;
  localparam int B_UNDER  = 20;
  localparam int B_OVER   = 21;
  localparam int B_RXUPD  = 22;

  // frame_config bit positions
  localparam int F_WLEN = 0;
  localparam int F_MODE = 16;
  localparam int F_LSB  = 18;
  localparam int F_CSPL = 19;
  localparam int F_EMU  = 20;

  // word length codes with irregular lengths
  localparam logic [4:0] WL_CODE_8  = 5'h00;
  localparam logic [4:0] WL_CODE_16 = 5'h01;
  localparam logic [4:0] WL_CODE_24 = 5'h02;
  localparam logic [5:0] WL_LEN_8   = 6'h08;
  localparam logic [5:0] WL_LEN_16  = 6'h10;
  localparam logic [5:0] WL_LEN_24  = 6'h18;
  localparam logic [5:0] SMS_ONE_C  = 6'h01;
  localparam logic [6:0] SMS_ONE_E  = 7'h01;
  localparam logic [6:0] SMS_FULL_W = 7'h20;

  // wire_mode_sel encodings
  localparam logic [1:0] MODE_4WIRE = 2'h0;
  localparam logic [1:0] MODE_3WIRE = 2'h1;

  localparam logic [31:0] SMS_RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic cs;
  } sms_pins_t;

  typedef struct packed {
    logic sample_edge_sel;
    logic clock_idle_level;
    logic master;
    logic en;
  } sms_ctrl_t;

  typedef struct packed {
    logic       emu;
    logic       cspol;
    logic       lsb;
    logic [1:0] mode;
    logic [4:0] wlen;
  } sms_frame_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_RUN, ST_HOLD} sms_mst_state_t;

endpackage

/* File: tb/sms_partner.sv */
// sms_partner: behavioural far-end serial device, slave or master as role says
// assumes: bench resolves the shared wires and sets the config variables
`timescale 1ns/1ps

module sms_partner (
  // resolved wires
  input  wire logic sck,
  input  wire logic cs,
  input  wire logic mosi,
  input  wire logic miso,
  // levels this end drives
  output logic      p_sck,
  output logic      p_cs,
  output logic      p_mosi,
  output logic      p_miso
);
  logic        role;
  logic        clock_idle_level;
  logic        sample_edge_sel;
  logic        cspol;
  logic        lsb;
  logic        sck_rel;
  logic [31:0] tx;
  logic [31:0] rx;
  int          n;
  int          smp;
  int          leads;
  realtime     t_first;
  realtime     t_last;

  function automatic logic bit_of(input int k);
    return lsb ? tx[k] : tx[n-1-k];
  endfunction

  task automatic put(input logic b);
    if (role) p_mosi = b;
    else p_miso = b;
  endtask

  initial begin
    role = 1'b0;
    {clock_idle_level, sample_edge_sel, cspol, lsb} = 4'h0;
    tx = 32'h0;
    rx = 32'h0;
    n = 8;
    {p_sck, p_cs, p_mosi, p_miso} = 4'h4;
  end

  // frame start presents the first bit; release leaves the inverse behind
  always @(cs) begin
    if (cs === cspol) begin
      smp = 0;
      leads = 0;
      rx = 32'h0;
      put(bit_of(0));
    end else begin
      sck_rel = sck;
      put(role ? ~p_mosi : ~p_miso);
    end
  end

  always @(sck) begin
    if (cs === cspol) begin
      if (sck !== clock_idle_level) begin
        leads++;
        if (leads == 1) t_first = $realtime;
        t_last = $realtime;
      end
      if ((sck !== clock_idle_level) ^ sample_edge_sel) begin
        if (smp < n) rx[lsb ? smp : n-1-smp] = role ? miso : mosi;
        smp++;
      end else if (smp < n) put(bit_of(smp));
    end
  end

  // park the link at its idle levels before this end acts as master
  task automatic idle;
    p_sck = clock_idle_level;
    p_cs  = ~cspol;
  endtask

  // master role: link clock of 160 ns, still outside frames
  task automatic run(input int cyc);
    p_sck = clock_idle_level;
    #7 p_cs = cspol;
    repeat (cyc) begin
      #80 p_sck = ~clock_idle_level;
      #80 p_sck = clock_idle_level;
    end
    #80 p_cs = ~cspol;
    #80;
  endtask
endmodule

/* File: tb/testbench.sv */
// testbench: register-level scenarios of the serial port against the far-end model
// assumes: sms_pkg, sms_core and sms_partner compiled first
`timescale 1ns/1ps

module testbench;
  import sms_pkg::*;
  logic              core_clk;
  logic              rst_n;
  logic              reg_wr;
  logic              reg_rd;
  logic [4:0]        reg_addr;
  logic [SMS_DW-1:0] reg_wdata;
  logic [SMS_DW-1:0] reg_rdata;
  logic [SMS_DW-1:0] rd_q;
  sms_pins_t         pin_in;
  sms_pins_t         pin_out;
  sms_pins_t         pin_oe;
  logic              p_sck, p_cs, p_mosi, p_miso;
  logic              sck_w, cs_w, mosi_w, miso_w;
  int                err_total;
  int                checked;

  assign sck_w  = pin_oe.sck ? pin_out.sck : p_sck;
  assign cs_w   = pin_oe.cs ? pin_out.cs : p_cs;
  assign mosi_w = pin_oe.mosi ? pin_out.mosi : p_mosi;
  assign miso_w = pin_oe.miso ? pin_out.miso : p_miso;
  assign pin_in = {sck_w, mosi_w, miso_w, cs_w};

  sms_core #(.ADDR_W(5)) dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  sms_partner partner (.sck(sck_w), .cs(cs_w), .mosi(mosi_w), .miso(miso_w),
    .p_sck(p_sck), .p_cs(p_cs), .p_mosi(p_mosi), .p_miso(p_miso));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask

  task automatic wait_cs(input logic lvl);
    int i;
    for (i = 0; i < 400 && cs_w !== lvl; i++) @(posedge core_clk);
    if (i == 400) begin
      err_total++;
      results();
    end
  endtask

  task automatic s_reset;
    wr(5'h08, 32'hFFFF_FFFF);
    wr(5'h10, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      rd(5'(i * 4));
      chk(rd_q, 32'h0);
    end
  endtask

  // cfg = {mode, lsb, cspol, sample_edge_sel, clock_idle_level}
  task automatic s_master(input logic [5:0] cfg, input logic [4:0] code,
                          input logic [31:0] tx, input logic [31:0] ptx);
    int          n;
    logic [31:0] ctl;
    logic [63:0] m;
    n = (code == 5'h00) ? 8 : (code == 5'h01) ? 16 : (code == 5'h02) ? 24 : code + 1;
    m = (64'h1 << n) - 64'h1;
    ctl = {28'h0, cfg[1:0], 2'h3};
    partner.role = 1'b0;
    {partner.lsb, partner.cspol, partner.sample_edge_sel, partner.clock_idle_level} = cfg[3:0];
    partner.n = n;
    partner.tx = ptx;
    wr(5'h04, {12'h0, cfg[2], cfg[3], cfg[5:4], 11'h0, code});
    wr(5'h00, ctl);
    repeat (2) @(posedge core_clk);
    chk(sck_w, cfg[0]);
    chk(cs_w, {~cfg[2]});
    wr(5'h0C, tx);
    wait_cs(cfg[2]);
    rd(5'h00);
    chk(rd_q[B_BUSY], 1'b1);
    wait_cs(~cfg[2]);
    chk(partner.leads, n);
    chk(partner.sck_rel, cfg[0]);
    chk($rtoi(partner.t_last - partner.t_first), (n - 1) * 40);
    chk(partner.rx, cfg[3] ? tx & m[31:0] : tx >> (32 - n));
    repeat (3) @(posedge core_clk);
    rd(5'h08);
    chk(rd_q, cfg[3] ? ptx : ptx << (32 - n));
    rd(5'h00);
    chk(rd_q, ctl | 32'h30);
    wr(5'h00, ctl);
    rd(5'h00);
    chk(rd_q, ctl);
  endtask

  // ph = {sample_edge_sel, clock_idle_level}
  task automatic s_slave(input logic [1:0] ph);
    logic [31:0] ctl;
    ctl = {28'h0, ph, 2'h1};
    partner.role = 1'b1;
    {partner.lsb, partner.cspol, partner.sample_edge_sel, partner.clock_idle_level} = {2'h1, ph};
    partner.n = 8;
    partner.tx = 32'hA5;
    partner.idle();
    wr(5'h04, 32'h000A_0000);
    wr(5'h00, ctl);
    wr(5'h0C, 32'h3C00_0000);
    fork
      partner.run(8);
      begin
        repeat (20) @(posedge core_clk);
        rd(5'h00);
        chk(rd_q[B_BUSY], 1'b1);
      end
    join
    chk(partner.rx, 32'h3C);
    rd(5'h08);
    chk(rd_q, 32'hA500_0000);
    partner.run(5);
    rd(5'h08);
    chk(rd_q, 32'hA000_0000);
    rd(5'h00);
    chk(rd_q & 32'h007D_0000, 32'h0010_0000);
    partner.run(8);
    partner.run(9);
    rd(5'h00);
    chk(rd_q & 32'h007D_0000, 32'h0035_0000);
    rd(5'h08);
    chk(rd_q, 32'hA500_0000);
    rd(5'h00);
    chk(rd_q & 32'h0005_0000, 32'h0);
    wr(5'h00, ctl);
    rd(5'h00);
    chk(rd_q & 32'h0030_0000, 32'h0);
  endtask

  task automatic s_three;
    partner.tx = 32'hC3;
    wr(5'h04, 32'h0011_0000);
    wr(5'h0C, 32'h5A00_0000);
    wr(5'h04, 32'h0001_0000);
    partner.run(8);
    wr(5'h04, 32'h0011_0000);
    rd(5'h08);
    chk(rd_q, 32'hC300_0000);
    chk(partner.rx, 32'h5A);
  endtask

  task automatic results;
    $display("mismatches=%0d comparisons=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    s_reset();
    s_master(6'h00, 5'h00, 32'hB700_0000, 32'h4D);
    s_master(6'h0F, 5'h03, 32'h0000_0009, 32'h6);
    s_master(6'h21, 5'h01, 32'hC0DE_0000, 32'h1234);
    s_master(6'h3A, 5'h1F, 32'h8000_0001, 32'h9ABC_DEF1);
    s_slave(2'h0);
    s_slave(2'h3);
    s_three();
    results();
  end
endmodule
